// ### sacp_port.sv
// Serial converter port: convert start, result shift-out, power modes.
// Assumes sck_i and convert_strobe_i are synchronous to clk_i and that
// the host keeps each level for at least one clk_i cycle.
//
// What this block does
// R1: Each serial clock rise during conversion advances conversion and output.
// R2: Any serial clock pulse wakes from nap or sleep.
// R3: Convert strobe rise holds input, starts conversion.
// R4: Two strobes without serial clock enter nap.
// R5: Four strobes without serial clock enter sleep.
// R6: Range select low unipolar, high bipolar.
// R7: Three-state output; word is previous conversion.
// R8: Conversion lasts fourteen serial clock cycles.
// R9: Acquisition runs from fourteenth edge to strobe.
// R10: Sleep clears settled flag; returns after 10 ms.
// R11: Result follows flag, MSB first, one per edge.
`timescale 1ns/1ps
module sacp_port
    import sacp_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = REF_SETTLE_CYC
) (
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    input  wire logic                sck_i,
    input  wire logic                convert_strobe_i,
    input  wire logic                range_select_i,
    input  wire logic [RESULT_W-1:0] input_code_i,
    output logic                     dout_o,
    output logic                     dout_oe_o,
    output logic                     hold_o,
    output logic                     nap_o,
    output logic                     sleep_o,
    output logic                     reference_settled_flag_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    sacp_state_t           state_reg;
    sacp_state_t           state_next;
    logic                  sck_q_reg;
    logic                  convert_strobe_q_reg;
    logic [3:0]            edge_cnt_reg;
    logic [3:0]            edge_cnt_next;
    logic [2:0]            pulse_cnt_reg;
    logic [2:0]            pulse_cnt_next;
    logic [RESULT_W-1:0]   held_reg;
    logic [RESULT_W-1:0]   held_next;
    logic                  bip_reg;
    logic                  bip_next;
    logic [RESULT_W-1:0]   result_reg;
    logic [RESULT_W-1:0]   result_next;
    sacp_pin_t             pin_reg;
    sacp_pin_t             pin_next;
    logic                  flag_reg;
    logic                  flag_next;
    logic                  hold_reg;
    logic                  hold_next;
    logic                  nap_reg;
    logic                  nap_next;
    logic                  sleep_reg;
    logic                  sleep_next;
    logic                  sck_rise;
    logic                  convert_strobe_rise;
    logic                  wake_sleep;
    logic                  enter_sleep;
    logic                  settle_done;

    // Bipolar output is two's complement: flip the offset-binary MSB
    function automatic logic [RESULT_W-1:0] code_for_range(
        input logic [RESULT_W-1:0] code,
        input logic                bipolar
    );
        code_for_range = code;
        if (bipolar) begin
            code_for_range[RESULT_W-1] = ~code[RESULT_W-1];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Edge detection on the host pins
    assign sck_rise  = sck_i & ~sck_q_reg;
    assign convert_strobe_rise = convert_strobe_i & ~convert_strobe_q_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sck_q_reg  <= 1'b0;
            convert_strobe_q_reg <= 1'b0;
        end else begin
            sck_q_reg  <= sck_i;
            convert_strobe_q_reg <= convert_strobe_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: conversion steps, pulse counting, power modes
    always_comb begin
        state_next     = state_reg;
        edge_cnt_next  = edge_cnt_reg;
        pulse_cnt_next = pulse_cnt_reg;
        held_next      = held_reg;
        bip_next       = bip_reg;
        result_next    = result_reg;
        pin_next       = pin_reg;
        wake_sleep     = 1'b0;
        enter_sleep    = 1'b0;
        // Any serial clock rise breaks a run of strobes
        if (sck_rise) begin
            pulse_cnt_next = '0;
        end else if (convert_strobe_rise && pulse_cnt_reg != SLEEP_PULSES) begin
            pulse_cnt_next = pulse_cnt_reg + 3'h1;
        end
        case (state_reg)
            SACP_ACQUIRE: begin
                if (convert_strobe_rise) begin
                    held_next     = input_code_i;        // [R3] [R9]
                    bip_next      = range_select_i;      // [R6]
                    edge_cnt_next = '0;
                    state_next    = SACP_CONVERT;
                end
            end
            SACP_CONVERT: begin
                if (sck_rise) begin
                    edge_cnt_next = edge_cnt_reg + 4'h1; // [R1]
                    if (edge_cnt_next == FLAG_EDGE) begin
                        pin_next.oe   = 1'b1;
                        pin_next.data = flag_reg;
                    end else if (edge_cnt_next < CONVERT_STROBE_SCK_EDGES) begin
                        // Word of the previous conversion [R7] [R11]
                        pin_next.data =
                            result_reg[4'(CONVERT_STROBE_SCK_EDGES - 4'h1)
                                       - edge_cnt_next];
                    end else begin
                        pin_next.oe  = 1'b0;             // [R7]
                        result_next  =
                            code_for_range(held_reg, bip_reg);
                        state_next   = SACP_ACQUIRE;     // [R8] [R9]
                    end
                end
            end
            SACP_NAP, SACP_SLEEP: begin
                if (sck_rise) begin
                    state_next = SACP_ACQUIRE;           // [R2]
                    wake_sleep = (state_reg == SACP_SLEEP);
                end
            end
            default: begin
                state_next = SACP_ACQUIRE;
            end
        endcase
        // Strobe runs take priority over a pending conversion
        if (!sck_rise && convert_strobe_rise) begin
            if (pulse_cnt_next == SLEEP_PULSES
                && state_reg != SACP_SLEEP) begin
                state_next  = SACP_SLEEP;                // [R5]
                enter_sleep = 1'b1;
                pin_next.oe = 1'b0;
            end else if (pulse_cnt_next == NAP_PULSES) begin
                state_next  = SACP_NAP;                  // [R4]
                pin_next.oe = 1'b0;
            end
        end
        // Mode pins from the next state, so each leaves a flip-flop
        hold_next  = (state_next == SACP_CONVERT);       // [R3]
        nap_next   = (state_next == SACP_NAP);           // [R4]
        sleep_next = (state_next == SACP_SLEEP);         // [R5]
    end

    // Registers only
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg     <= SACP_ACQUIRE;
            edge_cnt_reg  <= '0;
            pulse_cnt_reg <= '0;
            held_reg      <= RESULT_RST;
            bip_reg       <= 1'b0;
            result_reg    <= RESULT_RST;
            pin_reg       <= '0;
            hold_reg      <= 1'b0;
            nap_reg       <= 1'b0;
            sleep_reg     <= 1'b0;
        end else begin
            state_reg     <= state_next;
            edge_cnt_reg  <= edge_cnt_next;
            pulse_cnt_reg <= pulse_cnt_next;
            held_reg      <= held_next;
            bip_reg       <= bip_next;
            result_reg    <= result_next;
            pin_reg       <= pin_next;
            hold_reg      <= hold_next;
            nap_reg       <= nap_next;
            sleep_reg     <= sleep_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reference settled flag; the timer pulse wins over a same-cycle clear
    sacp_settle_timer #(
        .SETTLE_CYCLES (SETTLE_CYCLES)
    ) u_settle (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .start_i (wake_sleep),
        .clear_i (enter_sleep),
        .done_o  (settle_done)
    );

    always_comb begin
        flag_next = flag_reg;
        if (settle_done) begin
            flag_next = 1'b1;                            // [R10]
        end else if (enter_sleep) begin
            flag_next = 1'b0;                            // [R10]
        end
    end

    // Power-up assumes a settled reference; no reset pin on the part
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_reg <= 1'b1;
        end else begin
            flag_reg <= flag_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops
    assign dout_o                   = pin_reg.data;
    assign dout_oe_o                = pin_reg.oe;
    assign hold_o                   = hold_reg;
    assign nap_o                    = nap_reg;
    assign sleep_o                  = sleep_reg;
    assign reference_settled_flag_o = flag_reg;

endmodule

// ### sacp_pkg.sv
// Shared constants and types for the serial converter port.
// Assumes one 20 MHz system clock; all pins synchronous to it.
package sacp_pkg;

    // Clock rate and reference settling time
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned REF_SETTLE_MS   = 10;
    localparam int unsigned REF_SETTLE_CYC  =
        REF_SETTLE_MS * (CLK_HZ / 1000);

    // Conversion and power-down sequencing
    localparam logic [3:0] CONVERT_STROBE_SCK_EDGES   = 4'he;
    localparam logic [3:0] FLAG_EDGE        = 4'h1;
    localparam logic [2:0] NAP_PULSES       = 3'h2;
    localparam logic [2:0] SLEEP_PULSES     = 3'h4;
    localparam int unsigned RESULT_W        = 12;
    localparam logic [11:0] RESULT_RST      = 12'h000;

    // Operating state of the converter
    typedef enum logic [1:0] {
        SACP_ACQUIRE = 2'b00,
        SACP_CONVERT = 2'b01,
        SACP_NAP     = 2'b10,
        SACP_SLEEP   = 2'b11
    } sacp_state_t;

    // Serial data pin as driven by the device
    typedef struct packed {
        logic data;
        logic oe;
    } sacp_pin_t;

endpackage

// ### sacp_settle_timer.sv
// Reference settling timer: counts out the delay after a wake from sleep.
// Assumes start and clear are one-cycle pulses in the clk_i domain.
`timescale 1ns/1ps
module sacp_settle_timer
    import sacp_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = REF_SETTLE_CYC
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic start_i,
    input  wire logic clear_i,
    output logic      done_o
);

    logic [17:0] cnt_reg;
    logic [17:0] cnt_next;
    logic        run_reg;
    logic        run_next;
    logic        done_reg;
    logic        done_next;

    ////////////////////////////////////////////////////////////////////////
    // Next values; clear beats start so sleep always aborts the count
    always_comb begin
        cnt_next  = cnt_reg;
        run_next  = run_reg;
        done_next = 1'b0;
        if (clear_i) begin
            run_next = 1'b0;
            cnt_next = '0;
        end else if (start_i) begin
            run_next = 1'b1;
            cnt_next = '0;
        end else if (run_reg) begin
            if (cnt_reg == 18'(SETTLE_CYCLES - 1)) begin
                run_next  = 1'b0;
                done_next = 1'b1;  // One-cycle pulse
            end else begin
                cnt_next = cnt_reg + 18'h1;
            end
        end
    end

    // Registers only
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg  <= '0;
            run_reg  <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            run_reg  <= run_next;
            done_reg <= done_next;
        end
    end

    assign done_o = done_reg;

endmodule

// ### sacp_port_props.sv
// Checker for the serial converter port, watching its ports only.
// Assumes the host keeps sck_i and convert_strobe_i low during reset.
`timescale 1ns/1ps
module sacp_port_props
    import sacp_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = REF_SETTLE_CYC
) (
    input wire logic                clk_i,
    input wire logic                rst_n_i,
    input wire logic                sck_i,
    input wire logic                convert_strobe_i,
    input wire logic                range_select_i,
    input wire logic [RESULT_W-1:0] input_code_i,
    input wire logic                dout_o,
    input wire logic                dout_oe_o,
    input wire logic                hold_o,
    input wire logic                nap_o,
    input wire logic                sleep_o,
    input wire logic                reference_settled_flag_o
);
    logic        sck_q, convert_strobe_q, sck_rise, convert_strobe_rise;
    logic [3:0]  rise_cnt;
    logic [2:0]  strobe_cnt;
    int unsigned wake_cnt;
    assign sck_rise  = sck_i & ~sck_q;
    assign convert_strobe_rise = convert_strobe_i & ~convert_strobe_q;
    // Mirror counters; sck wins over a same-cycle strobe
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sck_q      <= 1'b0;
            convert_strobe_q     <= 1'b0;
            rise_cnt   <= 4'h0;
            strobe_cnt <= 3'h0;
            wake_cnt   <= 32'h0;
        end else begin
            sck_q    <= sck_i;
            convert_strobe_q   <= convert_strobe_i;
            rise_cnt <= hold_o ? rise_cnt + {3'h0, sck_rise} : 4'h0;
            if (sck_rise)
                strobe_cnt <= 3'h0;
            else if (convert_strobe_rise && strobe_cnt != 3'h4)
                strobe_cnt <= strobe_cnt + 3'h1;
            wake_cnt <= (sleep_o || reference_settled_flag_o) ?
                        32'h0 : wake_cnt + 32'h1;
        end
    end
    ////////////////////////////////////////
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_sck_rise;
        sck_rise;
    endsequence
    sequence s_lone_strobe;
        convert_strobe_rise && !sck_rise;
    endsequence
    chk_hold_start: assert property (
        s_lone_strobe ##0 (!hold_o && !nap_o && !sleep_o && strobe_cnt == 3'h0)
        |=> hold_o) else $error("hold missing after strobe");
    chk_flag_first: assert property (
        hold_o && !dout_oe_o && !convert_strobe_rise ##0 s_sck_rise
        |=> dout_oe_o && dout_o == $past(reference_settled_flag_o))
        else $error("first bit not the settled flag");
    chk_oe_in_convert_strobe: assert property (
        dout_oe_o |-> hold_o) else $error("output driven outside conversion");
    chk_dout_steady: assert property (
        !sck_rise && !convert_strobe_rise |=> $stable(dout_o))
        else $error("data moved without serial clock");
    chk_convert_strobe_length: assert property (
        hold_o && sck_rise && !convert_strobe_rise && rise_cnt < 4'hd |=> hold_o)
        else $error("conversion ended early");
    chk_convert_strobe_end: assert property (
        hold_o && sck_rise && !convert_strobe_rise && rise_cnt == 4'hd
        |=> !hold_o && !dout_oe_o) else $error("no acquire after edge 14");
    chk_nap_entry: assert property (
        s_lone_strobe ##0 strobe_cnt == 3'h1 |=> nap_o && !dout_oe_o)
        else $error("nap not entered");
    chk_sleep_entry: assert property (
        s_lone_strobe ##0 strobe_cnt == 3'h3
        |=> sleep_o && !reference_settled_flag_o) else $error("no sleep");
    chk_wake_pulse: assert property (
        (nap_o || sleep_o) ##0 s_sck_rise |=> !nap_o && !sleep_o)
        else $error("no wake on serial clock");
    chk_settle_max: assert property (
        wake_cnt <= SETTLE_CYCLES + 1) else $error("settle flag late");
endmodule
bind sacp_port sacp_port_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_props (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .sck_i(sck_i),
    .convert_strobe_i(convert_strobe_i), .range_select_i(range_select_i),
    .input_code_i(input_code_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
    .hold_o(hold_o), .nap_o(nap_o), .sleep_o(sleep_o),
    .reference_settled_flag_o(reference_settled_flag_o));

// ### sacp_host.sv
// Host model driving the serial clock and convert strobe pins.
// Assumes the port samples both pins on rising clk_i edges.
`timescale 1ns/1ps
module sacp_host (
    input  wire logic clk_i,
    output logic      sck_o,
    output logic      convert_strobe_o
);
    // Idle low, so no rise is seen at reset release
    initial begin
        sck_o = 1'b0;
        convert_strobe_o = 1'b0;
    end
    // One serial clock pulse, also the wake pulse
    task automatic pulse_sck();
        @(posedge clk_i);
        #1 sck_o = 1'b1;
        @(posedge clk_i);
        #1 sck_o = 1'b0;
    endtask
    // One strobe; repeats with sck still pick a power mode
    task automatic pulse_convert_strobe();
        @(posedge clk_i);
        #1 convert_strobe_o = 1'b1;
        @(posedge clk_i);
        #1 convert_strobe_o = 1'b0;
    endtask
endmodule

// ### test_serial_adc_conversion_port.sv
// Self-checking bench for the serial converter port.
// Assumes sacp_host drives the pins and the checker is bound in.
`timescale 1ns/1ps
module test_serial_adc_conversion_port;
    import sacp_pkg::*;
    localparam int unsigned SETTLE = 20; // Short settle keeps the run brief
    logic                clk_i = 1'b0, rst_n_i = 1'b0, range_select_i = 1'b0;
    logic [RESULT_W-1:0] input_code_i = 12'h000;
    logic                sck_i, convert_strobe_i, dout_o, dout_oe_o;
    logic                hold_o, nap_o, sleep_o, flag;
    int                  miscompares = 0, tests_run = 0;
    always #25 clk_i = ~clk_i;
    sacp_host host (.clk_i(clk_i), .sck_o(sck_i), .convert_strobe_o(convert_strobe_i));
    sacp_port #(.SETTLE_CYCLES(SETTLE)) uut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .sck_i(sck_i),
        .convert_strobe_i(convert_strobe_i), .range_select_i(range_select_i),
        .input_code_i(input_code_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
        .hold_o(hold_o), .nap_o(nap_o), .sleep_o(sleep_o),
        .reference_settled_flag_o(flag));
    ////////////////////////////////////////
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        if (miscompares == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Full conversion; the word read is that of the previous one
    task automatic convert(logic [11:0] code, logic rng, logic [12:0] exp);
        logic [12:0] word;
        @(posedge clk_i);
        #1 input_code_i = code;
        range_select_i = rng;
        host.pulse_convert_strobe();
        check("hold", hold_o, 16'h1);
        for (int k = 1; k <= 14; k++) begin
            host.pulse_sck();
            if (k < 14) begin
                check("oe", dout_oe_o, 16'h1);
                word = {word[11:0], dout_o};
            end
        end
        check("end", {hold_o, dout_oe_o}, 16'h0);
        check("word", word, exp);
    endtask
    // Two strobes to nap, wake, then the abandoned sample is lost
    task automatic nap_case();
        host.pulse_convert_strobe();
        host.pulse_convert_strobe();
        check("nap", {nap_o, hold_o, dout_oe_o}, 16'h4);
        host.pulse_sck();
        check("nap wake", nap_o, 16'h0);
        convert(12'h001, 1'b1, {1'b1, 12'h7ff});
    endtask
    // Four strobes to sleep; flag low until the settle time runs out
    task automatic sleep_case();
        int n;
        repeat (4) host.pulse_convert_strobe();
        check("sleep", {sleep_o, flag}, 16'h2);
        host.pulse_sck();
        check("sleep wake", {sleep_o, flag}, 16'h0);
        n = 0;
        while (flag !== 1'b1) begin
            if (n > SETTLE + 10) begin
                miscompares++;
                close_out();
            end
            @(posedge clk_i);
            #1 n++;
        end
        check("settle", 16'(n), 16'(SETTLE + 1));
        convert(12'h000, 1'b0, {1'b1, 12'h801});
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        check("reset", {dout_oe_o, hold_o, nap_o, sleep_o, flag},
              16'h1);
        convert(12'h5a3, 1'b0, {1'b1, 12'h000});
        convert(12'h8c1, 1'b1, {1'b1, 12'h5a3});
        convert(12'h7ff, 1'b0, {1'b1, 12'h0c1});
        nap_case();
        sleep_case();
        close_out();
    end
endmodule
